// *** cib_pkg.sv ***
// Package: encodings, field positions and cycle counts for the compact decode block
`default_nettype none
package cib_pkg;
  // ****************************************
  // Instruction format opcodes (top bits) and the two reserved branch condition codes
  // ****************************************
  localparam logic [3:0] CIB_OP_LDADDR = 4'hA;
  localparam logic [7:0] CIB_OP_SPADJ = 8'hB0;
  localparam logic [3:0] CIB_OP_PUSHPOP = 4'hB;
  localparam logic [3:0] CIB_OP_MULTI = 4'hC;
  localparam logic [3:0] CIB_OP_CBR = 4'hD;
  localparam logic [3:0] CIB_COND_UNDEF = 4'hE;
  localparam logic [3:0] CIB_COND_SWI = 4'hF;
  // ****************************************
  // Field positions
  // ****************************************
  localparam int CIB_LOAD_BIT = 11;
  localparam int CIB_SRC_BIT = 11;
  localparam int CIB_EXTRA_BIT = 8;
  localparam int CIB_SIGN_BIT = 7;
  localparam int CIB_COND_LSB = 8;
  localparam int CIB_RD_LSB = 8;
  // ****************************************
  // Constants
  // ****************************************
  localparam logic [31:0] CIB_PC_AHEAD = 32'h0000_0004;
  localparam logic [31:0] CIB_WORD = 32'h0000_0004;
  localparam logic [3:0] CIB_REG_SP = 4'hD;
  localparam logic [3:0] CIB_REG_LR = 4'hE;
  localparam logic [3:0] CIB_REG_PC = 4'hF;
  // Cycles for single-cycle data operations, a taken branch refill, and the load-multiple and PC-load tails
  localparam logic [1:0] CIB_CYC_ALU = 2'h1;
  localparam logic [1:0] CIB_CYC_BR_TAKEN = 2'h3;
  localparam logic [1:0] CIB_CYC_LDM_TAIL = 2'h1;
  localparam logic [1:0] CIB_CYC_PCLOAD_TAIL = 2'h2;
  typedef enum logic [2:0] {
    CIB_IDLE = 3'b000,
    CIB_XFER = 3'b001,
    CIB_WB = 3'b011,
    CIB_WAIT = 3'b010
  } cib_state_t;
endpackage : cib_pkg
`default_nettype wire

// *** cib_cond_eval.sv ***
// Condition-code evaluator for the conditional branch format
`default_nettype none
module cib_cond_eval
  import cib_pkg::*;
(
  input wire logic [3:0] cond,
  input wire logic flag_n,
  input wire logic flag_z,
  input wire logic flag_c,
  input wire logic flag_v,
  output logic taken
);
  wire n_eq_v = (flag_n == flag_v);
  wire [15:0] pass_vec = {
    1'b0, 1'b0,
    flag_z | ~n_eq_v,
    ~flag_z & n_eq_v,
    ~n_eq_v,
    n_eq_v,
    ~flag_c | flag_z,
    flag_c & ~flag_z,
    ~flag_v, flag_v, ~flag_n, flag_n, ~flag_c, flag_c, ~flag_z, flag_z};
  // Pairs of flag set/clear, then unsigned, then signed tests
  assign taken = pass_vec[cond];
endmodule // cib_cond_eval
`default_nettype wire

// *** cib_decode_exec.sv ***
// Decode and sequencing for load-address, stack, multiple-transfer and branch formats
// How it works
// - PC-sourced load-address uses instruction address plus 4 with bit 1 cleared.
// - Load-address immediate is the 8-bit field times four.
// - Load-address leaves the N, Z, C, V flags unchanged.
// - Stack adjust adds a signed constant to the stack pointer.
// - Stack adjust offset is sign plus 7-bit magnitude, scaled by four.
// - Sign bit set subtracts the scaled magnitude from the stack pointer.
// - Stack adjust changes no condition flags.
// - Stack is full descending; push pre-decrements, pop post-increments, both write back.
// - Push stores masked low registers and updates the stack pointer.
// - Push with extra bit also stores the link register, even with empty mask.
// - Pop with extra bit loads masked registers, then the program counter.
// - Store multiple writes masked registers at ascending addresses, then base write-back.
// - Load multiple reads masked registers at ascending addresses, then base write-back.
// - Conditions 0000 to 0111 test Z, C, N, V set then clear.
// - 1000 is C set and Z clear; 1001 is C clear or Z set.
// - 1010 N equals V, 1011 differs, 1100 adds Z clear, 1101 Z or differ.
// - Branch target is relative to instruction address plus four.
// - Branch offset field is sign-extended and doubled before adding.
// - Condition 1111 is handed off as software interrupt, not a branch.
// - Each instruction takes the same cycles as its full-width equivalent.
// - Load-address adds scaled constant to PC or SP and writes destination.
`default_nettype none
module cib_decode_exec
  import cib_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic instr_valid,
  input wire logic [15:0] instr_word,
  input wire logic [31:0] instr_addr,
  input wire logic [3:0] program_status_register,
  input wire logic [31:0] sp_value,
  input wire logic [31:0] base_value,
  input wire logic [31:0] lr_value,
  input wire logic [31:0] rf_rdata,
  input wire logic [31:0] mem_rdata,
  input wire logic mem_ready,
  output logic instr_ready,
  output logic [3:0] rf_raddr,
  output logic rf_we_r,
  output logic [3:0] rf_waddr_r,
  output logic [31:0] rf_wdata_r,
  output logic mem_req,
  output logic mem_write,
  output logic [31:0] mem_addr_r,
  output logic [31:0] mem_wdata,
  output logic pc_load_r,
  output logic [31:0] pc_target_r,
  output logic swi_req_r,
  output logic undef_req_r,
  output logic flags_we,
  output logic busy
);
  // ****************************************
  // Field extraction and format decode
  // ****************************************
  wire [3:0] top4 = instr_word[15:12];
  wire is_ldaddr = (top4 == CIB_OP_LDADDR);
  wire is_spadj = (instr_word[15:8] == CIB_OP_SPADJ);
  wire is_pushpop = (top4 == CIB_OP_PUSHPOP) && (instr_word[10:9] == 2'b10);
  wire is_multi = (top4 == CIB_OP_MULTI);
  wire is_cbr = (top4 == CIB_OP_CBR);
  wire load_bit = instr_word[CIB_LOAD_BIT];
  wire extra_bit = instr_word[CIB_EXTRA_BIT];
  wire [7:0] imm8 = instr_word[7:0];
  wire [6:0] stack_adjust_magnitude_field = instr_word[6:0];
  wire [7:0] cond_branch_offset_field = instr_word[7:0];
  wire [3:0] cond = instr_word[CIB_COND_LSB +: 4];
  wire [2:0] rd_lo = instr_word[CIB_RD_LSB +: 3];
  wire [31:0] pc_ahead = instr_addr + CIB_PC_AHEAD;
  wire [31:0] pc_aligned = {pc_ahead[31:2], 1'b0, pc_ahead[0]};
  wire [31:0] ldaddr_imm = {22'h000000, imm8, 2'b00};
  wire [31:0] ldaddr_base = instr_word[CIB_SRC_BIT] ? sp_value : pc_aligned;
  wire [31:0] ldaddr_sum = ldaddr_base + ldaddr_imm;
  wire [31:0] spadj_mag = {23'h000000, stack_adjust_magnitude_field, 2'b00};
  wire [31:0] spadj_sum = instr_word[CIB_SIGN_BIT] ? sp_value - spadj_mag : sp_value + spadj_mag;
  wire [31:0] br_off = {{23{cond_branch_offset_field[7]}}, cond_branch_offset_field, 1'b0};
  wire [31:0] br_target = pc_ahead + br_off;
  wire cond_taken;
  cib_cond_eval u_cond (
    .cond(cond),
    .flag_n(program_status_register[3]),
    .flag_z(program_status_register[2]),
    .flag_c(program_status_register[1]),
    .flag_v(program_status_register[0]),
    .taken(cond_taken)
  );
  // Count of words to transfer, including LR or PC when the extra bit asks for it
  function automatic logic [3:0] pop_count(input logic [7:0] m);
    logic [3:0] s;
    s = 4'h0;
    for (int i = 0; i < 8; i++) begin
      s = s + {3'b000, m[i]};
    end
    return s;
  endfunction
  wire pp_extra = is_pushpop & extra_bit;
  wire [3:0] xfer_cnt = pop_count(imm8) + {3'b000, pp_extra};
  wire [31:0] xfer_bytes = {26'h0000000, xfer_cnt, 2'b00};
  // Full descending: a push starts at the lowest slot it will fill
  wire [31:0] start_addr = is_pushpop ? (load_bit ? sp_value : sp_value - xfer_bytes) : base_value;
  wire [31:0] end_base = (is_pushpop && !load_bit) ? sp_value - xfer_bytes : start_addr + xfer_bytes;
  // ****************************************
  // Sequencer state
  // ****************************************
  cib_state_t state_r, state_nxt;
  logic [7:0] mask_r;
  logic extra_r, load_r, is_pp_r, pc_pend_r;
  logic [3:0] base_reg_r;
  logic [31:0] wb_value_r;
  logic [1:0] wait_r;
  wire [2:0] cur_reg;
  wire [7:0] mask_low = mask_r & (~mask_r + 8'h01);
  assign cur_reg = mask_low[1] ? 3'd1 : mask_low[2] ? 3'd2 : mask_low[3] ? 3'd3 : mask_low[4] ? 3'd4 :
                   mask_low[5] ? 3'd5 : mask_low[6] ? 3'd6 : mask_low[7] ? 3'd7 : 3'd0;
  wire xfer_extra = (mask_r == 8'h00) & extra_r;
  wire [3:0] xfer_reg = xfer_extra ? (load_r ? CIB_REG_PC : CIB_REG_LR) : {1'b0, cur_reg};
  wire beat_done = (state_r == CIB_XFER) & mem_ready;
  wire last_beat = beat_done & ((mask_r == mask_low && !extra_r) || xfer_extra);
  wire accept = instr_valid & (state_r == CIB_IDLE);
  wire start_xfer = accept & (is_pushpop | is_multi);
  assign instr_ready = (state_r == CIB_IDLE);
  assign busy = (state_r != CIB_IDLE);
  assign flags_we = 1'b0;
  assign rf_raddr = (xfer_extra & ~load_r) ? CIB_REG_LR : {1'b0, cur_reg};
  assign mem_req = (state_r == CIB_XFER);
  assign mem_write = (state_r == CIB_XFER) & ~load_r;
  assign mem_wdata = rf_rdata;
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      CIB_IDLE: begin
        if (start_xfer && xfer_cnt != 4'h0) begin
          state_nxt = CIB_XFER;
        end else if (accept && is_cbr && cond_taken && cond < CIB_COND_UNDEF) begin
          state_nxt = CIB_WAIT;
        end
      end
      CIB_XFER: begin
        if (last_beat) begin
          state_nxt = CIB_WB;
        end
      end
      CIB_WB: begin
        state_nxt = (load_r || pc_pend_r) ? CIB_WAIT : CIB_IDLE;
      end
      CIB_WAIT: begin
        if (wait_r == 2'h0) begin
          state_nxt = CIB_IDLE;
        end
      end
      default: state_nxt = CIB_IDLE;
    endcase
  end
  // ****************************************
  // Registered actions
  // ****************************************
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= CIB_IDLE;
      mask_r <= 8'h00;
      extra_r <= 1'b0;
      load_r <= 1'b0;
      is_pp_r <= 1'b0;
      pc_pend_r <= 1'b0;
      base_reg_r <= 4'h0;
      wb_value_r <= 32'h0000_0000;
      wait_r <= 2'h0;
      mem_addr_r <= 32'h0000_0000;
      rf_we_r <= 1'b0;
      rf_waddr_r <= 4'h0;
      rf_wdata_r <= 32'h0000_0000;
      pc_load_r <= 1'b0;
      pc_target_r <= 32'h0000_0000;
      swi_req_r <= 1'b0;
      undef_req_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      rf_we_r <= 1'b0;
      pc_load_r <= 1'b0;
      swi_req_r <= 1'b0;
      undef_req_r <= 1'b0;
      if (state_r == CIB_WAIT && wait_r != 2'h0) begin
        wait_r <= wait_r - 2'h1;
      end
      if (accept) begin
        if (is_ldaddr) begin
          rf_we_r <= 1'b1;
          rf_waddr_r <= {1'b0, rd_lo};
          rf_wdata_r <= ldaddr_sum;
        end else if (is_spadj) begin
          rf_we_r <= 1'b1;
          rf_waddr_r <= CIB_REG_SP;
          rf_wdata_r <= spadj_sum;
        end else if (is_pushpop || is_multi) begin
          mask_r <= imm8;
          extra_r <= pp_extra;
          load_r <= load_bit;
          is_pp_r <= is_pushpop;
          pc_pend_r <= pp_extra & load_bit;
          base_reg_r <= is_pushpop ? CIB_REG_SP : {1'b0, rd_lo};
          wb_value_r <= end_base;
          mem_addr_r <= start_addr;
          wait_r <= (pp_extra & load_bit) ? CIB_CYC_PCLOAD_TAIL : CIB_CYC_LDM_TAIL;
        end else if (is_cbr) begin
          if (cond == CIB_COND_SWI) begin
            swi_req_r <= 1'b1;
          end else if (cond == CIB_COND_UNDEF) begin
            undef_req_r <= 1'b1;
          end else if (cond_taken) begin
            pc_load_r <= 1'b1;
            pc_target_r <= br_target;
            wait_r <= CIB_CYC_BR_TAKEN - CIB_CYC_ALU;
          end
          // A failed test just retires; fetch carries on sequentially
        end
      end
      if (beat_done) begin
        mem_addr_r <= mem_addr_r + CIB_WORD;
        if (xfer_extra) begin
          extra_r <= 1'b0;
        end else begin
          mask_r <= mask_r & ~mask_low;
        end
        if (load_r && xfer_reg != CIB_REG_PC) begin
          rf_we_r <= 1'b1;
          rf_waddr_r <= xfer_reg;
          rf_wdata_r <= mem_rdata;
        end
        if (load_r && xfer_reg == CIB_REG_PC) begin
          pc_load_r <= 1'b1;
          pc_target_r <= mem_rdata;
        end
      end
      if (state_r == CIB_WB) begin
        // Base written after the data so a loaded base does not win unexpectedly
        rf_we_r <= 1'b1;
        rf_waddr_r <= base_reg_r;
        rf_wdata_r <= wb_value_r;
      end
    end
  end
  // ****************************************
  // Checks
  // ****************************************
  sequence s_swi_issue;
    instr_valid && instr_ready && is_cbr && cond == CIB_COND_SWI;
  endsequence
  a_ldaddr_pc_form: assert property (@(posedge ref_clk) disable iff (!rst_n)
    instr_valid && instr_ready && is_ldaddr && !instr_word[CIB_SRC_BIT] |=> rf_we_r && rf_wdata_r[1] == 1'b0 &&
    rf_wdata_r == (({$past(instr_addr)} + 32'h4) & 32'hFFFF_FFFD) + {22'h0, $past(imm8), 2'b00})
    else $error("load-address from pc gives wrong sum");
  a_ldaddr_no_flags: assert property (@(posedge ref_clk) disable iff (!rst_n)
    instr_valid && instr_ready && is_ldaddr |-> !flags_we ##1 !flags_we)
    else $error("load-address touched flags");
  a_spadj_result: assert property (@(posedge ref_clk) disable iff (!rst_n)
    instr_valid && instr_ready && is_spadj |=> rf_we_r && rf_waddr_r == CIB_REG_SP &&
    rf_wdata_r == ($past(instr_word[7]) ? $past(sp_value) - {23'h0, $past(instr_word[6:0]), 2'b00}
                                        : $past(sp_value) + {23'h0, $past(instr_word[6:0]), 2'b00}))
    else $error("stack adjust result wrong");
  a_branch_target: assert property (@(posedge ref_clk) disable iff (!rst_n)
    instr_valid && instr_ready && is_cbr && cond_taken && cond < 4'hE |=> pc_load_r &&
    pc_target_r == $past(instr_addr) + 32'h4 + {{23{$past(instr_word[7])}}, $past(instr_word[7:0]), 1'b0})
    else $error("branch target wrong");
  a_branch_fall: assert property (@(posedge ref_clk) disable iff (!rst_n)
    instr_valid && instr_ready && is_cbr && !cond_taken && cond < 4'hE |=> !pc_load_r && instr_ready)
    else $error("untaken branch redirected");
  a_swi_handoff: assert property (@(posedge ref_clk) disable iff (!rst_n)
    s_swi_issue |=> swi_req_r && !pc_load_r)
    else $error("swi encoding not handed off");
  a_push_first_addr: assert property (@(posedge ref_clk) disable iff (!rst_n)
    instr_valid && instr_ready && is_pushpop && !load_bit && xfer_cnt != 4'h0 |=>
    mem_req && mem_write && mem_addr_r == $past(sp_value) - {26'h0, $past(xfer_cnt), 2'b00})
    else $error("push does not start at full-descending slot");
  a_xfer_ascend: assert property (@(posedge ref_clk) disable iff (!rst_n)
    beat_done && !last_beat |=> mem_addr_r == $past(mem_addr_r) + 32'h4)
    else $error("multiple transfer address not ascending");
  a_base_wb: assert property (@(posedge ref_clk) disable iff (!rst_n)
    last_beat |=> state_r == CIB_WB ##1 rf_we_r && rf_waddr_r == base_reg_r)
    else $error("base write-back missing");
  a_push_lr_empty: assert property (@(posedge ref_clk) disable iff (!rst_n)
    instr_valid && instr_ready && is_pushpop && !load_bit && extra_bit && imm8 == 8'h00 |=>
    mem_write && rf_raddr == CIB_REG_LR)
    else $error("push of link register alone missing");
  a_undef_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
    instr_valid && instr_ready && is_cbr && cond == CIB_COND_UNDEF |=> undef_req_r && !pc_load_r)
    else $error("undefined condition not flagged");
  a_pop_pc_load: assert property (@(posedge ref_clk) disable iff (!rst_n)
    beat_done && load_r && xfer_reg == CIB_REG_PC |=> pc_load_r && pc_target_r == $past(mem_rdata))
    else $error("popped program counter not loaded");
  a_cond_zero_pair: assert property (@(posedge ref_clk) disable iff (!rst_n)
    instr_valid && instr_ready && is_cbr && cond[3:1] == 3'b000 |=>
    pc_load_r == ($past(cond[0]) ^ $past(program_status_register[2])))
    else $error("zero flag branch decision wrong");
  a_spadj_no_flags: assert property (@(posedge ref_clk) disable iff (!rst_n)
    instr_valid && instr_ready && is_spadj |-> !flags_we ##1 !flags_we)
    else $error("stack adjust touched flags");
  // Taken branch holds the sequencer for the refill cycles
  a_branch_refill: assert property (@(posedge ref_clk) disable iff (!rst_n)
    instr_valid && instr_ready && is_cbr && cond_taken && cond < CIB_COND_UNDEF |=> busy ##1 busy ##1 busy ##1 !busy)
    else $error("taken branch cycle count wrong");
endmodule // cib_decode_exec
`default_nettype wire

// *** cib_mem_model.sv ***
// Partner model: data memory and register file read port facing the decode block
`default_nettype none
module cib_mem_model (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic stall_en,
  input wire logic mem_req,
  input wire logic mem_write,
  input wire logic [31:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  input wire logic [3:0] rf_raddr,
  output logic [31:0] rf_rdata,
  output logic [31:0] mem_rdata,
  output logic mem_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****************************************
  // Storage and answers
  // ****************************************
  logic [31:0] mem [logic [31:0]];
  logic [31:0] rd_val;
  // Bumped on every store so a read of a just-written word sees the new value
  int wr_cnt = 0;
  // Registers hold word-aligned marks so a popped link value is a clean target
  assign rf_rdata = 32'h5EED_0000 | {26'h0, rf_raddr, 2'h0};
  always @(mem_addr or mem_ready or wr_cnt) begin
    rd_val = mem.exists(mem_addr) ? mem[mem_addr] : (mem_addr ^ 32'hA5A5_0000);
  end
  // While mem_ready is low the data is inverted, so a stale sample cannot match
  assign mem_rdata = mem_ready ? rd_val : ~rd_val;
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_ready <= 1'b0;
    end else begin
      if (mem_req && mem_ready && mem_write) begin
        mem[mem_addr] = mem_wdata;
        wr_cnt = wr_cnt + 1;
      end
      mem_ready <= stall_en ? 1'($urandom % 2) : 1'b1;
    end
  end
endmodule // cib_mem_model
`default_nettype wire

// *** compact_isa_decode_stack_branch_test.sv ***
// Self-checking bench for the compact decode block
`default_nettype none
`define CHK(nm, ex, gt) begin compares++; if ((gt) !== (ex)) mism(nm, 65'(ex), 65'(gt)); end
module compact_isa_decode_stack_branch_test import cib_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk = 1'b0, rst_n = 1'b0, instr_valid = 1'b0, stall_en = 1'b0;
  logic [15:0] instr_word = 16'h0000;
  logic [31:0] instr_addr = 32'h0, sp_value = 32'h0, base_value = 32'h0;
  logic [3:0] program_status_register = 4'h0;
  logic [31:0] rf_rdata, mem_rdata, mem_addr_r, mem_wdata, rf_wdata_r, pc_target_r;
  logic mem_ready, instr_ready, rf_we_r, mem_req, mem_write, pc_load_r, swi_req_r, undef_req_r, flags_we, busy;
  logic [3:0] rf_raddr, rf_waddr_r;
  int err_total = 0, compares = 0, n_swi = 0, n_und = 0, n_flag = 0, exp_swi = 0, exp_und = 0;
  logic [35:0] exp_rf[$], obs_rf[$];
  logic [64:0] exp_mem[$], obs_mem[$];
  logic [31:0] exp_pc[$], obs_pc[$], tmem [logic [31:0]];
  cib_decode_exec u_cib_decode_exec (.ref_clk, .rst_n, .instr_valid, .instr_word, .instr_addr,
    .program_status_register, .sp_value, .base_value, .lr_value(32'h0), .rf_rdata, .mem_rdata, .mem_ready,
    .instr_ready, .rf_raddr, .rf_we_r, .rf_waddr_r, .rf_wdata_r, .mem_req, .mem_write, .mem_addr_r,
    .mem_wdata, .pc_load_r, .pc_target_r, .swi_req_r, .undef_req_r, .flags_we, .busy);
  cib_mem_model u_cib_mem_model (.ref_clk, .rst_n, .stall_en, .mem_req, .mem_write, .mem_addr(mem_addr_r),
    .mem_wdata, .rf_raddr, .rf_rdata, .mem_rdata, .mem_ready);
  initial begin
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    if (rf_we_r) obs_rf.push_back({rf_waddr_r, rf_wdata_r});
    if (mem_req && mem_ready) obs_mem.push_back({mem_addr_r, mem_write, mem_write ? mem_wdata : 32'h0});
    if (pc_load_r) obs_pc.push_back(pc_target_r);
    n_swi += int'(swi_req_r);
    n_und += int'(undef_req_r);
    n_flag += int'(flags_we);
  end
  // ****************************************
  // Reference model
  // ****************************************
  function automatic logic [31:0] rv(int r);
    return 32'h5EED_0000 + 32'(r * 4);
  endfunction
  function automatic logic [31:0] mrd(logic [31:0] a);
    return tmem.exists(a) ? tmem[a] : a ^ 32'hA5A5_0000;
  endfunction
  task automatic beats(int regs[$], logic [31:0] a, bit wr);
    foreach (regs[i]) begin
      if (wr) begin
        exp_mem.push_back({a, 1'b1, rv(regs[i])});
        tmem[a] = rv(regs[i]);
      end else begin
        exp_mem.push_back({a, 1'b0, 32'h0});
        if (regs[i] == 15) exp_pc.push_back(mrd(a));
        else exp_rf.push_back({4'(regs[i]), mrd(a)});
      end
      a += 32'h4;
    end
  endtask
  task automatic predict(logic [15:0] w);
    int regs[$];
    logic [31:0] b, off;
    logic n, z, c, v, tk;
    {n, z, c, v} = program_status_register;
    off = {23'h0, w[6:0], 2'h0};
    for (int i = 0; i < 8; i++) if (w[i]) regs.push_back(i);
    case (w[15:12])
      CIB_OP_LDADDR: begin
        b = w[11] ? sp_value : (instr_addr + 32'h4) & ~32'h2;
        exp_rf.push_back({1'b0, w[10:8], b + {22'h0, w[7:0], 2'h0}});
      end
      CIB_OP_PUSHPOP: begin
        if (w[11:8] == 4'h0) exp_rf.push_back({CIB_REG_SP, w[7] ? sp_value - off : sp_value + off});
        else begin
          if (w[8]) regs.push_back(w[11] ? 15 : 14);
          b = w[11] ? sp_value : sp_value - 32'(regs.size() * 4);
          beats(regs, b, !w[11]);
          if (regs.size() != 0) exp_rf.push_back({CIB_REG_SP, w[11] ? b + 32'(regs.size() * 4) : b});
        end
      end
      CIB_OP_MULTI: begin
        beats(regs, base_value, !w[11]);
        if (regs.size() != 0) exp_rf.push_back({1'b0, w[10:8], base_value + 32'(regs.size() * 4)});
      end
      CIB_OP_CBR: begin
        case (w[11:8])
          4'h0, 4'h1: tk = z;
          4'h2, 4'h3: tk = c;
          4'h4, 4'h5: tk = n;
          4'h6, 4'h7: tk = v;
          4'h8, 4'h9: tk = c && !z;
          4'hA, 4'hB: tk = n == v;
          default: tk = !z && n == v;
        endcase
        tk ^= w[8];
        if (w[11:8] == CIB_COND_SWI) exp_swi++;
        else if (w[11:8] == CIB_COND_UNDEF) exp_und++;
        else if (tk) exp_pc.push_back(instr_addr + 32'h4 + {{23{w[7]}}, w[7:0], 1'b0});
      end
      default: ;
    endcase
  endtask
  // ****************************************
  // Driving and checking
  // ****************************************
  task automatic mism(string nm, logic [64:0] e, logic [64:0] g);
    err_total++;
    $display("MISMATCH %s expected %h seen %h", nm, e, g);
  endtask
  task automatic end_sim();
    $display("Counts: compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic run(logic [15:0] w);
    int k;
    predict(w);
    instr_word = w;
    instr_valid = 1'b1;
    for (k = 0; k < 50 && instr_ready !== 1'b1; k++) @(negedge ref_clk);
    if (k == 50) begin
      err_total++;
      end_sim();
    end
    @(negedge ref_clk);
    instr_valid = 1'b0;
    for (k = 0; k < 200 && busy !== 1'b0; k++) @(negedge ref_clk);
    if (k == 200) begin
      err_total++;
      end_sim();
    end
    repeat (3) @(negedge ref_clk);
  endtask
  task automatic check(string nm);
    `CHK("rf write count", exp_rf.size(), obs_rf.size())
    `CHK("mem beat count", exp_mem.size(), obs_mem.size())
    `CHK("pc load count", exp_pc.size(), obs_pc.size())
    foreach (exp_rf[i]) if (i < obs_rf.size()) `CHK("rf write", exp_rf[i], obs_rf[i])
    foreach (exp_mem[i]) if (i < obs_mem.size()) `CHK("mem beat", exp_mem[i], obs_mem[i])
    foreach (exp_pc[i]) if (i < obs_pc.size()) `CHK("pc target", exp_pc[i], obs_pc[i])
    `CHK("swi pulses", exp_swi, n_swi)
    `CHK("undef pulses", exp_und, n_und)
    `CHK("flag writes", 0, n_flag)
    exp_rf.delete();
    obs_rf.delete();
    exp_mem.delete();
    obs_mem.delete();
    exp_pc.delete();
    obs_pc.delete();
    exp_swi = 0;
    exp_und = 0;
    n_swi = 0;
    n_und = 0;
    n_flag = 0;
    $display("Test %s finished, mismatches so far %0d", nm, err_total);
  endtask
  initial begin
    logic [15:0] pp[5] = '{16'hB501, 16'hBD01, 16'hB500, 16'hB4FF, 16'hBC00};
    logic [31:0] pp_sp[5] = '{32'h100, 32'hF8, 32'h100, 32'h100, 32'hE0};
    void'($urandom(32'hAAB244C5));
    repeat (6) @(negedge ref_clk);
    rst_n = 1'b1;
    @(negedge ref_clk);
    sp_value = 32'h0000_2000;
    for (int i = 0; i < 4; i++) begin
      instr_addr = 32'h0000_0102 + 32'(i * 2);
      program_status_register = 4'($urandom);
      run({CIB_OP_LDADDR, 1'(i), 3'(i + 5), 8'(i * 85)});
      run({CIB_OP_SPADJ, i[1], i[0] ? 7'h7F : 7'h43});
    end
    check("load_address_and_stack_adjust");
    stall_en = 1'b1;
    for (int i = 0; i < 5; i++) begin
      sp_value = pp_sp[i];
      run(pp[i]);
    end
    check("push_pop");
    for (int i = 0; i < 6; i++) begin
      base_value = $urandom & 32'h0000_FFFC;
      run({CIB_OP_MULTI, 1'(i), 3'($urandom), i == 5 ? 8'hFF : 8'($urandom)});
    end
    check("multiple_transfer");
    for (int c = 0; c < 16; c++) begin
      for (int f = 0; f < 16; f++) begin
        program_status_register = 4'(f);
        instr_addr = $urandom & 32'h00FF_FFFE;
        run({CIB_OP_CBR, 4'(c), 8'($urandom)});
      end
    end
    check("conditional_branch");
    for (int i = 0; i < 40; i++) begin
      sp_value = $urandom & 32'h00FF_FFFC;
      base_value = $urandom & 32'h00FF_FFFC;
      instr_addr = $urandom & 32'h00FF_FFFE;
      program_status_register = 4'($urandom);
      case ($urandom % 5)
        0: run({CIB_OP_LDADDR, 12'($urandom)});
        1: run({CIB_OP_SPADJ, 8'($urandom)});
        2: run({CIB_OP_PUSHPOP, 1'($urandom), 2'b10, 9'($urandom)});
        3: run({CIB_OP_MULTI, 12'($urandom)});
        default: run({CIB_OP_CBR, 12'($urandom)});
      endcase
    end
    check("random_mix");
    end_sim();
  end
endmodule // compact_isa_decode_stack_branch_test
`default_nettype wire
